// File: vtq_pkg.sv
package vtq_pkg;
	// ==========================================================
	// register indices (byte address = 4 * index)
	localparam logic [7:0] IDX_PRIO_MAP_LO = 8'h0C;
	localparam logic [7:0] IDX_PRIO_MAP_HI = 8'h0D;
	localparam logic [7:0] IDX_P1_CTRL0 = 8'h10;
	localparam logic [7:0] IDX_P2_CTRL0 = 8'h20;
	localparam logic [7:0] IDX_P3_CTRL0 = 8'h30;
	localparam logic [7:0] IDX_CTRL2_OFS = 8'h02;
	localparam logic [7:0] IDX_DTAG_HI_OFS = 8'h03;
	localparam logic [7:0] IDX_DTAG_LO_OFS = 8'h04;
	localparam logic [7:0] IDX_DSCP_BASE = 8'h60;
	localparam logic [7:0] IDX_INS_SEL = 8'hC2;
	localparam logic [7:0] IDX_LAST_MAPPED = 8'hC6;
	localparam logic [7:0] IDX_STAT_INS = 8'hD0;
	localparam logic [7:0] IDX_STAT_STRIP = 8'hD1;
	localparam logic [7:0] IDX_STAT_STATE = 8'hD2;
	// ==========================================================
	// field positions
	localparam int CTRL0_STRIP_BIT = 1;
	localparam int CTRL0_INS_BIT = 2;
	localparam int CTRL0_PRIO_1P_BIT = 5;
	localparam int CTRL0_DSCP_BIT = 6;
	localparam int CTRL2_LEARN_DIS_BIT = 0;
	localparam int CTRL2_RX_EN_BIT = 1;
	localparam int CTRL2_TX_EN_BIT = 2;
	localparam int INS_SEL_BITS = 6;
	// ==========================================================
	// reset values
	localparam logic [7:0] CTRL2_RST = 8'h06;
	localparam logic [7:0] REG_RST = 8'h00;
	// ==========================================================
	// frame layout and tag constants
	localparam logic [3:0] TAG_POS = 4'hC;
	localparam logic [3:0] AFTER_TAG = 4'hD;
	localparam logic [1:0] TAG_LEN_M1 = 2'h3;
	localparam logic [15:0] TAG_PROTO_ID = 16'h8100;
	localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
	localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
	localparam logic [1:0] PROC_PORT = 2'h2;
	// ==========================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum {ED_IDLE, ED_PASS, ED_INS, ED_SKIP, ED_FCS} vtq_ed_state_t;
endpackage : vtq_pkg

// File: vtq_port_ctrl.sv
`timescale 1ns/1ps
module vtq_port_ctrl #(
	parameter int ADDR_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cls_valid,
	input wire logic [1:0] cls_port,
	input wire logic cls_tagged,
	input wire logic [2:0] cls_vlan_prio,
	input wire logic cls_is_ip,
	input wire logic [7:0] cls_tos,
	output logic cls_done,
	output logic [1:0] cls_queue_prio,
	output logic [2:0] cls_tag_prio,
	input wire logic fwd_valid,
	input wire logic [1:0] fwd_src,
	input wire logic [2:0] fwd_dst_mask,
	input wire logic fwd_override,
	output logic fwd_done,
	output logic [2:0] fwd_allowed_mask,
	output logic fwd_learn,
	input wire logic s_valid,
	output logic s_ready,
	input wire logic [7:0] s_data,
	input wire logic s_last,
	input wire logic [1:0] s_src_port,
	input wire logic [1:0] s_dst_port,
	input wire logic s_tagged,
	output logic m_valid,
	input wire logic m_ready,
	output logic [7:0] m_data,
	output logic m_last
);
	import vtq_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic [7:0] ctrl0_idx(input logic [1:0] p);
		case (p)
			2'h0: ctrl0_idx = IDX_P1_CTRL0;
			2'h1: ctrl0_idx = IDX_P2_CTRL0;
			default: ctrl0_idx = IDX_P3_CTRL0;
		endcase
	endfunction : ctrl0_idx

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] x;
		x = c ^ {24'h00_0000, d};
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
		end
		crc_byte = x;
	endfunction : crc_byte

	// source/egress pairing inside the selection byte: two bits per egress port
	function automatic int ins_sel_bit(input logic [1:0] src, input logic [1:0] dst);
		int s;
		s = (src > dst) ? int'(src) - 1 : int'(src);
		ins_sel_bit = int'(dst) * 2 + s;
	endfunction : ins_sel_bit

	// ==========================================================
	// register file and bus slave
	logic [7:0] regs_r [0:255];
	logic [7:0] regs_nxt [0:255];
	logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic [7:0] aw_idx_r, aw_idx_nxt;
	logic [7:0] wdat_r, wdat_nxt;
	logic wen_r, wen_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [7:0] ins_cnt_r, ins_cnt_nxt, strip_cnt_r, strip_cnt_nxt;
	vtq_ed_state_t st_r, st_nxt;
	logic [7:0] ar_idx;

	assign s_axi_awready = !aw_have_r && !bvalid_r;
	assign s_axi_wready = !w_have_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign ar_idx = s_axi_araddr[9:2];

	// address and data are held apart, the write lands once both are in
	always_comb begin
		regs_nxt = regs_r;
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		aw_idx_nxt = aw_idx_r;
		wdat_nxt = wdat_r;
		wen_nxt = wen_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_nxt = 1'b1;
			aw_idx_nxt = s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_nxt = 1'b1;
			wdat_nxt = s_axi_wdata[7:0];
			wen_nxt = s_axi_wstrb[0];
		end
		if (aw_have_r && w_have_r && !bvalid_r) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			if (aw_idx_r <= IDX_LAST_MAPPED) begin
				bresp_nxt = RESP_OKAY;
				if (wen_r) begin
					regs_nxt[aw_idx_r] = wdat_r;
				end
			end else begin
				bresp_nxt = RESP_SLVERR;
			end
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		// status words reflect the editor, they are read-only
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			if (ar_idx <= IDX_LAST_MAPPED) begin
				rdata_nxt[7:0] = regs_r[ar_idx];
			end else if (ar_idx == IDX_STAT_INS) begin
				rdata_nxt[7:0] = ins_cnt_r;
			end else if (ar_idx == IDX_STAT_STRIP) begin
				rdata_nxt[7:0] = strip_cnt_r;
			end else if (ar_idx == IDX_STAT_STATE) begin
				rdata_nxt[7:0] = {5'h00, 3'(st_r)};
			end else begin
				rresp_nxt = RESP_SLVERR;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	// port control 2 comes up in forwarding, everything else cleared
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 256; i++) begin
				regs_r[i] <= (i == 18 || i == 34 || i == 50) ? CTRL2_RST : REG_RST;
			end
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_idx_r <= 8'h00;
			wdat_r <= 8'h00;
			wen_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else begin
			regs_r <= regs_nxt;
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			aw_idx_r <= aw_idx_nxt;
			wdat_r <= wdat_nxt;
			wen_r <= wen_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ==========================================================
	// ingress priority classification
	logic cls_done_r, cls_done_nxt;
	logic [1:0] cls_q_r, cls_q_nxt;
	logic [2:0] cls_tp_r, cls_tp_nxt;
	logic [7:0] cls_c0;
	logic [2:0] dflt_prio;
	logic [15:0] prio_map;
	logic [5:0] code_pt;
	logic [7:0] dscp_reg;

	assign cls_done = cls_done_r;
	assign cls_queue_prio = cls_q_r;
	assign cls_tag_prio = cls_tp_r;

	always_comb begin
		cls_c0 = regs_r[ctrl0_idx(cls_port)];
		dflt_prio = regs_r[ctrl0_idx(cls_port) + IDX_DTAG_HI_OFS][7:5];
		prio_map = {regs_r[IDX_PRIO_MAP_HI], regs_r[IDX_PRIO_MAP_LO]};
		code_pt = cls_tos[7:2];
		dscp_reg = regs_r[IDX_DSCP_BASE + {4'h0, code_pt[5:2]}];
		cls_done_nxt = cls_valid;
		cls_q_nxt = cls_q_r;
		cls_tp_nxt = cls_tp_r;
		if (cls_valid) begin
			cls_q_nxt = 2'h0;
			cls_tp_nxt = cls_vlan_prio;
			if (cls_c0[CTRL0_PRIO_1P_BIT] && cls_tagged && cls_vlan_prio > dflt_prio) begin
				cls_tp_nxt = dflt_prio;
			end
			if (cls_c0[CTRL0_PRIO_1P_BIT] && cls_tagged) begin
				cls_q_nxt = prio_map[{cls_vlan_prio, 1'b0} +: 2];
			end else if (cls_c0[CTRL0_DSCP_BIT] && cls_is_ip) begin
				cls_q_nxt = dscp_reg[{code_pt[1:0], 1'b0} +: 2];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cls_done_r <= 1'b0;
			cls_q_r <= 2'h0;
			cls_tp_r <= 3'h0;
		end else begin
			cls_done_r <= cls_done_nxt;
			cls_q_r <= cls_q_nxt;
			cls_tp_r <= cls_tp_nxt;
		end
	end

	// ==========================================================
	// spanning tree forwarding filter
	logic fwd_done_r, fwd_done_nxt, fwd_learn_r, fwd_learn_nxt;
	logic [2:0] fwd_mask_r, fwd_mask_nxt;
	logic [1:0] p_tx, p_rx, p_ld;

	assign fwd_done = fwd_done_r;
	assign fwd_allowed_mask = fwd_mask_r;
	assign fwd_learn = fwd_learn_r;

	always_comb begin
		for (int p = 0; p < 2; p++) begin
			p_tx[p] = regs_r[ctrl0_idx(2'(p)) + IDX_CTRL2_OFS][CTRL2_TX_EN_BIT];
			p_rx[p] = regs_r[ctrl0_idx(2'(p)) + IDX_CTRL2_OFS][CTRL2_RX_EN_BIT];
			p_ld[p] = regs_r[ctrl0_idx(2'(p)) + IDX_CTRL2_OFS][CTRL2_LEARN_DIS_BIT];
		end
	end

	always_comb begin
		fwd_done_nxt = fwd_valid;
		fwd_mask_nxt = fwd_mask_r;
		fwd_learn_nxt = fwd_learn_r;
		if (fwd_valid) begin
			fwd_mask_nxt = fwd_dst_mask;
			fwd_learn_nxt = 1'b1;
			if (fwd_src != PROC_PORT) begin
				// bit 0 picks port 1 or 2
				fwd_learn_nxt = !p_ld[fwd_src[0]];
				if (!p_rx[fwd_src[0]]) begin
					// override frames still reach the processor
					fwd_mask_nxt = fwd_override ? (fwd_dst_mask & 3'b100) : 3'b000;
				end
				// a closed egress port takes traffic only from the processor
				for (int q = 0; q < 2; q++) begin
					if (!p_tx[q]) begin
						fwd_mask_nxt[q] = 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fwd_done_r <= 1'b0;
			fwd_mask_r <= 3'h0;
			fwd_learn_r <= 1'b0;
		end else begin
			fwd_done_r <= fwd_done_nxt;
			fwd_mask_r <= fwd_mask_nxt;
			fwd_learn_r <= fwd_learn_nxt;
		end
	end

	// ==========================================================
	// egress tag editor with fresh frame check sequence
	logic [3:0] cnt_r, cnt_nxt;
	logic [1:0] sub_r, sub_nxt;
	logic ins_r, ins_nxt, strip_r, strip_nxt;
	logic [15:0] tcf_r, tcf_nxt;
	logic [31:0] crc_r, crc_nxt;
	logic [7:0] o_data_r, o_data_nxt;
	logic o_valid_r, o_valid_nxt, o_last_r, o_last_nxt;
	logic adv;
	logic [31:0] tag_word, fcs_word;
	logic [7:0] e_c0, sel;

	assign m_valid = o_valid_r;
	assign m_data = o_data_r;
	assign m_last = o_last_r;
	// output slot is free when empty or being drained this cycle
	assign adv = !o_valid_r || m_ready;
	// protocol id then tag control, most significant byte first
	assign tag_word = {TAG_PROTO_ID, tcf_r};
	assign fcs_word = ~crc_r;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sub_nxt = sub_r;
		ins_nxt = ins_r;
		strip_nxt = strip_r;
		tcf_nxt = tcf_r;
		crc_nxt = crc_r;
		o_data_nxt = o_data_r;
		o_valid_nxt = o_valid_r && !m_ready;
		o_last_nxt = o_last_r;
		ins_cnt_nxt = ins_cnt_r;
		strip_cnt_nxt = strip_cnt_r;
		s_ready = 1'b0;
		e_c0 = regs_r[ctrl0_idx(s_dst_port)];
		sel = regs_r[IDX_INS_SEL];
		case (st_r)
			ED_IDLE: begin
				if (s_valid) begin
					ins_nxt = e_c0[CTRL0_INS_BIT] && !s_tagged && s_src_port != s_dst_port
						&& sel[ins_sel_bit(s_src_port, s_dst_port)];
					// only tagged frames lose a tag
					strip_nxt = e_c0[CTRL0_STRIP_BIT] && s_tagged;
					// default tag of the ingress port
					tcf_nxt = {regs_r[ctrl0_idx(s_src_port) + IDX_DTAG_HI_OFS],
						regs_r[ctrl0_idx(s_src_port) + IDX_DTAG_LO_OFS]};
					ins_cnt_nxt = ins_cnt_r + {7'h00, ins_nxt};
					strip_cnt_nxt = strip_cnt_r + {7'h00, strip_nxt};
					cnt_nxt = 4'h0;
					sub_nxt = 2'h0;
					crc_nxt = CRC_INIT;
					st_nxt = ED_PASS;
				end
			end
			ED_PASS: begin
				// tag sits right after the source address
				if (cnt_r == TAG_POS && ins_r) begin
					st_nxt = ED_INS;
				end else if (cnt_r == TAG_POS && strip_r) begin
					st_nxt = ED_SKIP;
				end else begin
					s_ready = adv;
					if (s_valid && adv) begin
						o_data_nxt = s_data;
						o_valid_nxt = 1'b1;
						o_last_nxt = 1'b0;
						crc_nxt = crc_byte(crc_r, s_data);
						if (cnt_r < AFTER_TAG) begin
							cnt_nxt = cnt_r + 4'h1;
						end
						if (s_last) begin
							sub_nxt = 2'h0;
							st_nxt = ED_FCS;
						end
					end
				end
			end
			ED_INS: begin
				if (adv) begin
					o_data_nxt = tag_word[{~sub_r, 3'b000} +: 8];
					o_valid_nxt = 1'b1;
					o_last_nxt = 1'b0;
					crc_nxt = crc_byte(crc_r, tag_word[{~sub_r, 3'b000} +: 8]);
					sub_nxt = sub_r + 2'h1;
					if (sub_r == TAG_LEN_M1) begin
						cnt_nxt = AFTER_TAG;
						st_nxt = ED_PASS;
					end
				end
			end
			ED_SKIP: begin
				// dropped bytes never wait on the output side
				s_ready = 1'b1;
				if (s_valid) begin
					sub_nxt = sub_r + 2'h1;
					if (s_last) begin
						sub_nxt = 2'h0;
						st_nxt = ED_FCS;
					end else if (sub_r == TAG_LEN_M1) begin
						cnt_nxt = AFTER_TAG;
						st_nxt = ED_PASS;
					end
				end
			end
			ED_FCS: begin
				// regenerated check sequence, low byte first
				if (adv) begin
					o_data_nxt = fcs_word[{sub_r, 3'b000} +: 8];
					o_valid_nxt = 1'b1;
					o_last_nxt = (sub_r == TAG_LEN_M1);
					sub_nxt = sub_r + 2'h1;
					if (sub_r == TAG_LEN_M1) begin
						st_nxt = ED_IDLE;
					end
				end
			end
			default: begin
				st_nxt = ED_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= ED_IDLE;
			cnt_r <= 4'h0;
			sub_r <= 2'h0;
			ins_r <= 1'b0;
			strip_r <= 1'b0;
			tcf_r <= 16'h0000;
			crc_r <= CRC_INIT;
			o_data_r <= 8'h00;
			o_valid_r <= 1'b0;
			o_last_r <= 1'b0;
			ins_cnt_r <= 8'h00;
			strip_cnt_r <= 8'h00;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sub_r <= sub_nxt;
			ins_r <= ins_nxt;
			strip_r <= strip_nxt;
			tcf_r <= tcf_nxt;
			crc_r <= crc_nxt;
			o_data_r <= o_data_nxt;
			o_valid_r <= o_valid_nxt;
			o_last_r <= o_last_nxt;
			ins_cnt_r <= ins_cnt_nxt;
			strip_cnt_r <= strip_cnt_nxt;
		end
	end
endmodule : vtq_port_ctrl

// File: vtq_port_ctrl_bench.sv
`timescale 1ns/1ps
module vtq_port_ctrl_bench;
	import vtq_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, cls_port, cls_queue_prio, fwd_src, s_src_port, s_dst_port, rsp;
	logic cls_valid, cls_tagged, cls_is_ip, cls_done, fwd_valid, fwd_override, fwd_done, fwd_learn;
	logic [2:0] cls_vlan_prio, cls_tag_prio, fwd_dst_mask, fwd_allowed_mask;
	logic [7:0] cls_tos, s_data, m_data;
	logic s_valid, s_ready, s_last, s_tagged, m_valid, m_ready, m_last;
	int errors, num_checks;
	vtq_port_ctrl #(.ADDR_W(12)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.cls_valid, .cls_port, .cls_tagged, .cls_vlan_prio, .cls_is_ip, .cls_tos, .cls_done, .cls_queue_prio,
		.cls_tag_prio, .fwd_valid, .fwd_src, .fwd_dst_mask, .fwd_override, .fwd_done, .fwd_allowed_mask,
		.fwd_learn, .s_valid, .s_ready, .s_data, .s_last, .s_src_port, .s_dst_port, .s_tagged, .m_valid,
		.m_ready, .m_data, .m_last);
	vtq_sink_model u_sink (.aclk, .aresetn, .m_valid, .m_data, .m_last, .m_ready);
	// ==========================================================
	// shared helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= {2'b00, i, 2'b00};
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// each channel released at its own taking edge
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] i);
		@(posedge aclk);
		s_axi_araddr <= {2'b00, i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rdv = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic cls(input logic [1:0] p, input logic t, input logic [2:0] pr, input logic ip,
		input logic [7:0] tos, input logic [1:0] eq, input logic [2:0] et);
		@(posedge aclk);
		cls_port <= p;
		cls_tagged <= t;
		cls_vlan_prio <= pr;
		cls_is_ip <= ip;
		cls_tos <= tos;
		cls_valid <= 1'b1;
		@(posedge aclk);
		cls_valid <= 1'b0;
		@(posedge aclk);
		chk(cls_done, 1);
		chk(cls_queue_prio, eq);
		chk(cls_tag_prio, et);
	endtask : cls
	// processor side may aim traffic at a disabled port, its mask is never filtered
	task automatic fwd(input logic [7:0] c1, input logic [7:0] c2, input logic [1:0] src, input logic [2:0] dst,
		input logic ovr, input logic [2:0] em, input logic el);
		wr(IDX_P1_CTRL0 + IDX_CTRL2_OFS, c1);
		wr(IDX_P2_CTRL0 + IDX_CTRL2_OFS, c2);
		@(posedge aclk);
		fwd_src <= src;
		fwd_dst_mask <= dst;
		fwd_override <= ovr;
		fwd_valid <= 1'b1;
		@(posedge aclk);
		fwd_valid <= 1'b0;
		@(posedge aclk);
		chk(fwd_done, 1);
		chk(fwd_allowed_mask, em);
		chk(fwd_learn, el);
	endtask : fwd
	function automatic logic [31:0] fcs(input logic [7:0] q[$]);
		logic [31:0] c;
		c = CRC_INIT;
		foreach (q[k]) begin
			c ^= {24'h00_0000, q[k]};
			repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		return ~c;
	endfunction : fcs
	// mode 0 unchanged, 1 tag inserted, 2 tag stripped
	task automatic frm(input logic [1:0] sp, input logic [1:0] dp, input logic tg, input int mode);
		logic [7:0] f[$];
		logic [7:0] e[$];
		logic [31:0] c;
		int i;
		for (i = 0; i < 18; i++)
			f.push_back(8'(i + 1));
		if (tg)
			f[12] = 8'h81;
		e = f;
		if (mode == 1)
			e = {f[0:11], 8'h81, 8'h00, 8'h40, 8'h05, f[12:$]};
		if (mode == 2)
			e = {f[0:11], f[16:$]};
		c = fcs(e);
		e = {e, c[7:0], c[15:8], c[23:16], c[31:24]};
		u_sink.got.delete();
		// a stale end index from the previous frame must not pass for this one
		u_sink.last_at = -1;
		@(posedge aclk);
		s_src_port <= sp;
		s_dst_port <= dp;
		s_tagged <= tg;
		s_data <= f[0];
		s_valid <= 1'b1;
		i = 0;
		while (i < f.size()) begin
			@(posedge aclk);
			if (s_ready === 1'b1) begin
				i++;
				s_data <= f[i % f.size()];
				s_last <= (i == f.size() - 1);
				if (i == f.size())
					s_valid <= 1'b0;
			end
		end
		for (i = 0; i < 200 && u_sink.got.size() < e.size(); i++)
			@(posedge aclk);
		chk(u_sink.got.size(), e.size());
		chk(u_sink.last_at, e.size() - 1);
		foreach (e[k])
			chk(u_sink.got[k], e[k]);
	endtask : frm
	// ==========================================================
	// scenarios
	task automatic t_regs;
		rd(IDX_P1_CTRL0 + IDX_CTRL2_OFS);
		chk(rdv, 32'h0000_0006);
		rd(IDX_P2_CTRL0);
		chk(rdv, 32'h0000_0000);
		rd(8'hC8);
		chk(rsp, RESP_SLVERR);
		wr(8'hC8, 8'h55);
		chk(rsp, RESP_SLVERR);
		$display("register test done");
	endtask : t_regs
	task automatic t_prio;
		wr(IDX_PRIO_MAP_LO, 8'hE4);
		wr(IDX_PRIO_MAP_HI, 8'h1B);
		wr(IDX_P1_CTRL0, 8'h20);
		wr(IDX_P1_CTRL0 + IDX_DTAG_HI_OFS, 8'hA0);
		cls(2'h0, 1'b1, 3'h6, 1'b0, 8'h00, 2'h1, 3'h5);
		cls(2'h0, 1'b1, 3'h3, 1'b0, 8'h00, 2'h3, 3'h3);
		cls(2'h1, 1'b1, 3'h6, 1'b0, 8'h00, 2'h0, 3'h6);
		wr(IDX_P2_CTRL0, 8'h40);
		wr(IDX_DSCP_BASE + 8'h0A, 8'h20);
		cls(2'h1, 1'b0, 3'h0, 1'b1, 8'hA8, 2'h2, 3'h0);
		$display("priority test done");
	endtask : t_prio
	task automatic t_stp;
		fwd(8'h01, 8'h06, 2'h0, 3'h2, 1'b0, 3'h0, 1'b0);
		fwd(8'h01, 8'h06, 2'h0, 3'h4, 1'b1, 3'h4, 1'b0);
		fwd(8'h01, 8'h06, 2'h0, 3'h6, 1'b0, 3'h0, 1'b0);
		fwd(8'h00, 8'h06, 2'h0, 3'h2, 1'b0, 3'h0, 1'b1);
		fwd(8'h06, 8'h06, 2'h0, 3'h6, 1'b0, 3'h6, 1'b1);
		fwd(8'h06, 8'h00, 2'h2, 3'h3, 1'b0, 3'h3, 1'b1);
		fwd(8'h06, 8'h01, 2'h1, 3'h1, 1'b0, 3'h0, 1'b0);
		$display("spanning tree test done");
	endtask : t_stp
	task automatic t_edit;
		wr(IDX_P2_CTRL0, 8'h04);
		wr(IDX_INS_SEL, 8'h00);
		frm(2'h0, 2'h1, 1'b0, 0);
		// port 1 selected too, so only its enable bit keeps the frame untagged
		wr(IDX_INS_SEL, 8'h05);
		wr(IDX_P1_CTRL0 + IDX_DTAG_HI_OFS, 8'h40);
		wr(IDX_P1_CTRL0 + IDX_DTAG_LO_OFS, 8'h05);
		frm(2'h0, 2'h1, 1'b0, 1);
		frm(2'h0, 2'h1, 1'b1, 0);
		frm(2'h1, 2'h0, 1'b0, 0);
		wr(IDX_P2_CTRL0, 8'h02);
		frm(2'h0, 2'h1, 1'b1, 2);
		frm(2'h0, 2'h1, 1'b0, 0);
		rd(IDX_STAT_INS);
		chk(rdv, 32'h0000_0001);
		rd(IDX_STAT_STRIP);
		chk(rdv, 32'h0000_0001);
		rd(IDX_STAT_STATE);
		chk(rdv, 32'h0000_0000);
		$display("frame edit test done");
	endtask : t_edit
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	// ==========================================================
	// clock, watchdog, main sequence
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// generous span: the whole run needs a few hundred cycles
	initial begin
		#(50 * 20000);
		errors++;
		final_report();
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
		{cls_valid, cls_port, cls_tagged, cls_vlan_prio, cls_is_ip, cls_tos} = 16'h0000;
		{fwd_valid, fwd_src, fwd_dst_mask, fwd_override} = 7'h00;
		{s_valid, s_data, s_last, s_src_port, s_dst_port, s_tagged} = 15'h0000;
		errors = 0;
		num_checks = 0;
		aresetn = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_prio();
		t_stp();
		t_edit();
		final_report();
	end
endmodule : vtq_port_ctrl_bench

// File: vtq_port_ctrl_sva.sv
`timescale 1ns/1ps
// ==========================================================
// boundary checker for the port controller
module vtq_port_ctrl_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic cls_valid,
	input wire logic cls_tagged,
	input wire logic [2:0] cls_vlan_prio,
	input wire logic cls_done,
	input wire logic [2:0] cls_tag_prio,
	input wire logic fwd_valid,
	input wire logic [1:0] fwd_src,
	input wire logic [2:0] fwd_dst_mask,
	input wire logic fwd_done,
	input wire logic [2:0] fwd_allowed_mask,
	input wire logic fwd_learn,
	input wire logic m_valid,
	input wire logic m_ready,
	input wire logic [7:0] m_data,
	input wire logic m_last
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// request shapes
	sequence s_untagged_req;
		cls_valid && !cls_tagged;
	endsequence
	sequence s_proc_req;
		fwd_valid && fwd_src == 2'h2;
	endsequence
	sequence s_end_taken;
		m_valid && m_ready && m_last;
	endsequence
	// ==========================================================
	// properties
	AST_CLS_DONE: assert property (cls_valid |=> cls_done)
		else $error("classify answer missing");
	AST_TAG_PRIO: assert property (s_untagged_req |=> cls_tag_prio == $past(cls_vlan_prio))
		else $error("untagged priority altered");
	AST_FWD_DONE: assert property (fwd_valid |=> fwd_done)
		else $error("filter answer missing");
	AST_PROC_FREE: assert property (s_proc_req |=> fwd_allowed_mask == $past(fwd_dst_mask) && fwd_learn)
		else $error("processor traffic filtered");
	AST_MASK_SUB: assert property (fwd_valid |=> (fwd_allowed_mask & ~$past(fwd_dst_mask)) == 3'h0)
		else $error("port allowed beyond request");
	AST_M_HOLD: assert property (m_valid && !m_ready |=> m_valid && $stable(m_data) && $stable(m_last))
		else $error("output byte changed while stalled");
	AST_LAST_ONE: assert property (s_end_taken |=> !(m_valid && m_last))
		else $error("frame end repeated");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule : vtq_port_ctrl_sva

bind vtq_port_ctrl vtq_port_ctrl_sva u_sva (.aclk, .aresetn, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.cls_valid, .cls_tagged, .cls_vlan_prio, .cls_done, .cls_tag_prio, .fwd_valid, .fwd_src, .fwd_dst_mask,
	.fwd_done, .fwd_allowed_mask, .fwd_learn, .m_valid, .m_ready, .m_data, .m_last);

// File: vtq_sink_model.sv
`timescale 1ns/1ps
// ==========================================================
// egress link partner: collects bytes, stalls now and then
module vtq_sink_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic m_valid,
	input wire logic [7:0] m_data,
	input wire logic m_last,
	output logic m_ready
);
	logic [7:0] got[$];
	int last_at;
	logic [1:0] cnt_r;
	// one stall in four so the editor meets back-pressure mid-frame
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= 2'h0;
			m_ready <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 2'h1;
			m_ready <= (cnt_r != 2'h2);
			if (m_valid && m_ready) begin
				if (m_last)
					last_at = got.size();
				got.push_back(m_data);
			end
		end
	end
endmodule : vtq_sink_model
